// [isp_defines.vh]
// Constants for the interleaved sample input port.
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
`define ISP_ADR_CTRL      4'h0
`define ISP_ADR_ALARM_SEL 4'h1
`define ISP_ADR_STATUS    4'h2
`define ISP_ADR_MASK      4'h3
`define ISP_ADR_CHAN_A    4'h4
`define ISP_ADR_CHAN_B    4'h5
`define ISP_ADR_PHASE     4'h6
`define ISP_ADR_SDO       4'h7
`define ISP_CTRL_FOUR_WIRE 0
`define ISP_CTRL_SWAP      1
`define ISP_CTRL_CLK_OUT   2
`define ISP_CTRL_PHASE     3
`define ISP_CTRL_PHASE_8   4
`define ISP_CTRL_MF_LO     5
`define ISP_CTRL_MF_HI     6
`define ISP_CTRL_SDIO_OE   7
`define ISP_CTRL_SDIO_OUT  8
`define ISP_CTRL_RESET     9'h000
`define ISP_EV_A_WORD      0
`define ISP_EV_B_WORD      1
`define ISP_EV_FLAG_ERR    2
`define ISP_EV_SYNC        3
`define ISP_EV_PHASE       4
`define ISP_EV_RESET       5
`define ISP_EV_W           6
`define ISP_MF_SYNC        2'h0
`define ISP_MF_TX_EN       2'h1
`define ISP_MF_SLEEP       2'h2
`define ISP_CLK_DIV_HALF   8'h08
`endif

// [isp_edge.v]
// Rising edge finder on a synchronised latch clock.
`default_nettype none
module isp_edge (
  input  wire clk_i,
  input  wire rst_i,
  input  wire lvl_i,
  output wire rise_o
);
  reg last;
  // Remember the previous sample to spot a low to high step.
  always @(posedge clk_i) begin
    if (rst_i) begin
      last <= 1'b0;
    end else begin
      last <= lvl_i;
    end
  end
  assign rise_o = lvl_i & ~last;
endmodule
`default_nettype wire

// [isp_host_model.sv]
// Behavioural host that sends one interleaved word pair per request.
`default_nettype none
module isp_host_model (
  input  wire logic        go_i,
  input  wire logic [13:0] word_a_i,
  input  wire logic [13:0] word_b_i,
  output logic             lclk_o,
  output logic [13:0]      data_o,
  output logic             marker_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One 80 ns latch period per word, data steady 20 ns before the rise.
  task automatic put(input logic m, input logic [13:0] d);
    marker_o = m;
    data_o = d;
    #20 lclk_o = 1'b1;
    #40 lclk_o = 1'b0;
    #20;
  endtask
  // The clock rests low between pairs and data and marker are driven back
  // to zero, so no stale word lingers on the bus.
  initial begin
    {lclk_o, data_o, marker_o} = '0;
    forever begin
      @(posedge go_i);
      put(1'b1, word_a_i);
      put(1'b0, word_b_i);
      {data_o, marker_o} = '0;
    end
  end
endmodule
`default_nettype wire

// [isp_port.v]
// Interleaved sample input port with control pins and Wishbone registers.
//
// Added by the designer: the Wishbone register port and the address map.
`default_nettype none
`include "isp_defines.vh"
module isp_port #(
  parameter DW = 14,
  parameter PW = 8
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [5:2]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output wire          irq_o,
  input  wire [DW-1:0] sample_data_i,
  input  wire          channel_marker_i,
  input  wire          data_clk_i,
  output reg           data_clk_o,
  output wire          data_clk_oe_o,
  input  wire          chip_reset_n_i,
  input  wire          serial_frame_n_i,
  input  wire          serial_data_i,
  output wire          serial_data_o,
  output wire          serial_data_oe_o,
  output wire          alarm_or_read_out_o,
  input  wire          multi_func_i,
  output wire          sync_pulse_o,
  output wire          tx_enable_o,
  output wire          sleep_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  wire [DW-1:0] data_s;
  wire          marker_s;
  wire          dclk_s;
  wire          crst_s;
  wire          frame_n_s;
  wire          mf_s;
  wire          sdi_s;

  isp_sync2 #(.W(DW + 6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sample_data_i, channel_marker_i, data_clk_i, ~chip_reset_n_i,
             serial_frame_n_i, multi_func_i, serial_data_i}),
    .q_o   ({data_s, marker_s, dclk_s, crst_s, frame_n_s, mf_s, sdi_s})
  );

  // The reset pin is carried inverted so that the synchroniser's own clear
  // reads as no chip reset; a released rst_i is then not stretched by two
  // cycles while the pin level walks through the flip-flops.
  wire srst = rst_i | crst_s;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg  [8:0]           ctrl;
  reg  [`ISP_EV_W-1:0] alarm_sel;
  reg  [`ISP_EV_W-1:0] status;
  reg  [`ISP_EV_W-1:0] mask;
  reg  [DW-1:0]        chan_a;
  reg  [DW-1:0]        chan_b;
  reg  [2*PW-1:0]      phase_word;
  reg                  sdo_bit;
  reg  [`ISP_EV_W-1:0] events;

  wire four_wire = ctrl[`ISP_CTRL_FOUR_WIRE];
  wire swap      = ctrl[`ISP_CTRL_SWAP];
  wire clk_out   = ctrl[`ISP_CTRL_CLK_OUT];
  wire phase_md  = ctrl[`ISP_CTRL_PHASE];
  wire phase_8   = ctrl[`ISP_CTRL_PHASE_8];
  wire [1:0] mf_mode = ctrl[`ISP_CTRL_MF_HI:`ISP_CTRL_MF_LO];

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  // Address match, used by both the write and the read paths.
  function is_adr;
    input [3:0] a;
    input [3:0] want;
    begin
      is_adr = (a == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Latch clock: taken from the host, or divided down and driven out.

  reg  [7:0] div_cnt;
  wire       own_rise;
  wire       host_rise;

  // Divider runs always so switching source needs no restart.
  always @(posedge clk_i) begin
    if (srst) begin
      div_cnt    <= 8'h00;
      data_clk_o <= 1'b0;
    end else if (div_cnt == `ISP_CLK_DIV_HALF - 8'h01) begin
      div_cnt    <= 8'h00;
      data_clk_o <= ~data_clk_o;
    end else begin
      div_cnt    <= div_cnt + 8'h01;
    end
  end
  assign own_rise      = clk_out & (div_cnt == `ISP_CLK_DIV_HALF - 8'h01)
                         & ~data_clk_o;
  assign data_clk_oe_o = clk_out;

  isp_edge u_edge (
    .clk_i  (clk_i),
    .rst_i  (srst),
    .lvl_i  (dclk_s),
    .rise_o (host_rise)
  );

  // Own clock mode samples the bus when our own edge goes out; the host
  // must have the data settled two cycles before then, as the bus is seen two cycles late.
  wire latch = clk_out ? own_rise : host_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Demultiplexing of the sample stream.

  wire is_first = marker_s ^ swap;
  reg  first_seen;
  reg  phase_hi_seen;

  // Channel words and phase halves are steered by the marker.
  always @(posedge clk_i) begin
    if (srst) begin
      chan_a        <= {DW{1'b0}};
      chan_b        <= {DW{1'b0}};
      phase_word    <= {2*PW{1'b0}};
      first_seen    <= 1'b0;
      phase_hi_seen <= 1'b0;
      events[2:0]   <= 3'h0;
      events[4]     <= 1'b0;
    end else begin
      events[2:0] <= 3'h0;
      events[4]   <= 1'b0;
      if (latch && phase_md && !phase_8) begin
        phase_word <= {data_s, {(2*PW-DW){1'b0}}};
        events[4]  <= 1'b1;
      end else if (latch && phase_md) begin
        if (marker_s) begin
          phase_word[2*PW-1:PW] <= data_s[DW-1:DW-PW];
          phase_hi_seen         <= 1'b1;
        end else begin
          phase_word[PW-1:0] <= data_s[DW-1:DW-PW];
          events[4]          <= phase_hi_seen;
          phase_hi_seen      <= 1'b0;
        end
      end else if (latch && is_first) begin
        chan_a     <= data_s;
        events[0]  <= 1'b1;
        events[2]  <= first_seen; // two first words in a row
        first_seen <= 1'b1;
      end else if (latch) begin
        chan_b     <= data_s;
        events[1]  <= 1'b1;
        events[2]  <= ~first_seen;
        first_seen <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multi-function pin.

  reg mf_last;
  always @(posedge clk_i) begin
    if (srst) begin
      mf_last   <= 1'b0;
      events[3] <= 1'b0;
    end else begin
      mf_last   <= mf_s;
      events[3] <= (mf_mode == `ISP_MF_SYNC) & mf_s & ~mf_last;
    end
  end
  assign sync_pulse_o = events[3];
  assign tx_enable_o  = (mf_mode == `ISP_MF_TX_EN) & mf_s;
  assign sleep_o      = (mf_mode == `ISP_MF_SLEEP) & mf_s;

  // Reset event: first cycle after rst_i or a chip reset has ended.
  reg boot;
  always @(posedge clk_i) begin
    if (srst) begin
      boot      <= 1'b1;
      events[5] <= 1'b0;
    end else begin
      boot      <= 1'b0;
      events[5] <= boot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and sticky status; an event wins over a clear.

  always @(posedge clk_i) begin
    if (srst) begin
      ctrl      <= `ISP_CTRL_RESET;
      alarm_sel <= {`ISP_EV_W{1'b0}};
      mask      <= {`ISP_EV_W{1'b0}};
      status    <= {`ISP_EV_W{1'b0}};
      sdo_bit   <= 1'b1;
    end else begin
      if (wb_wr && is_adr(wb_adr_i, `ISP_ADR_CTRL))
        ctrl <= {wb_sel_i[1] ? wb_dat_i[8] : ctrl[8], wb_dat_i[7:0]};
      if (wb_wr && is_adr(wb_adr_i, `ISP_ADR_ALARM_SEL))
        alarm_sel <= wb_dat_i[`ISP_EV_W-1:0];
      if (wb_wr && is_adr(wb_adr_i, `ISP_ADR_MASK))
        mask <= wb_dat_i[`ISP_EV_W-1:0];
      if (wb_wr && is_adr(wb_adr_i, `ISP_ADR_SDO))
        sdo_bit <= wb_dat_i[0];
      if (wb_wr && is_adr(wb_adr_i, `ISP_ADR_STATUS))
        status <= (status & ~wb_dat_i[`ISP_EV_W-1:0]) | events;
      else
        status <= status | events;
    end
  end

  // Read mux and single-cycle acknowledge.
  always @(posedge clk_i) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (1'b1)
          is_adr(wb_adr_i, `ISP_ADR_CTRL):      wb_dat_o[8:0] <= ctrl;
          is_adr(wb_adr_i, `ISP_ADR_ALARM_SEL):
            wb_dat_o[`ISP_EV_W-1:0] <= alarm_sel;
          is_adr(wb_adr_i, `ISP_ADR_STATUS):
            wb_dat_o[`ISP_EV_W-1:0] <= status;
          is_adr(wb_adr_i, `ISP_ADR_MASK):
            wb_dat_o[`ISP_EV_W-1:0] <= mask;
          is_adr(wb_adr_i, `ISP_ADR_CHAN_A):    wb_dat_o[DW-1:0] <= chan_a;
          is_adr(wb_adr_i, `ISP_ADR_CHAN_B):    wb_dat_o[DW-1:0] <= chan_b;
          is_adr(wb_adr_i, `ISP_ADR_PHASE):
            wb_dat_o[2*PW-1:0] <= phase_word;
          is_adr(wb_adr_i, `ISP_ADR_SDO):
            wb_dat_o[1:0] <= {frame_n_s, sdo_bit};
          default:                              wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm, interrupt and serial data pins.

  // The alarm stays active low; in four-wire mode the pin carries read data.
  wire alarm_hit = |(status & alarm_sel);
  assign alarm_or_read_out_o = four_wire ? sdo_bit : ~alarm_hit;
  assign irq_o = |(status & mask);

  // Read turnaround only while a frame is open and only in three-wire mode.
  assign serial_data_oe_o = ~four_wire & ~frame_n_s
                            & ctrl[`ISP_CTRL_SDIO_OE];
  assign serial_data_o    = sdo_bit;

endmodule
`default_nettype wire

// [isp_port_asserts.sv]
// Port-level assertions for the interleaved sample input port.
`default_nettype none
module isp_port_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        irq_o,
  input wire logic        data_clk_o,
  input wire logic        data_clk_oe_o,
  input wire logic        serial_frame_n_i,
  input wire logic        serial_data_oe_o,
  input wire logic        alarm_or_read_out_o,
  input wire logic        sync_pulse_o,
  input wire logic        tx_enable_o,
  input wire logic        sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // A bus request and the eight-cycle high half of our own latch clock.
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence high_half;
    data_clk_o [*8] ##1 !data_clk_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Bus answers come one cycle late, last one cycle, and are never unasked.
  ack_answer_a: assert property (bus_req |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
    else $error("ack without request");
  dat_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // The edge after reset still shows irq, alarm, data pin enable and clock enable at rest.
  reset_quiet_a: assert property ($past(rst_i) |-> !irq_o &&
    alarm_or_read_out_o && !serial_data_oe_o && !data_clk_oe_o)
    else $error("outputs not at rest after reset");
  // A frame closed for four cycles must not see us driving the data pin.
  frame_oe_a: assert property (
    serial_frame_n_i [*4] |-> !serial_data_oe_o)
    else $error("data pin driven outside frame");
  // Own clock high halves are 8 cycles; stopping it aborts the check.
  clk_half_a: assert property (disable iff (rst_i || !data_clk_oe_o)
    $rose(data_clk_o) |-> high_half)
    else $error("own latch clock half period wrong");
  sync_pulse_a: assert property (sync_pulse_o |=> !sync_pulse_o)
    else $error("sync pulse longer than one cycle");
  mf_excl_a: assert property (
    $onehot0({sync_pulse_o, tx_enable_o, sleep_o}))
    else $error("two multi-function outputs active");
endmodule
bind isp_port isp_port_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .irq_o(irq_o), .data_clk_o(data_clk_o),
  .data_clk_oe_o(data_clk_oe_o), .serial_frame_n_i(serial_frame_n_i),
  .serial_data_oe_o(serial_data_oe_o), .sleep_o(sleep_o),
  .alarm_or_read_out_o(alarm_or_read_out_o),
  .sync_pulse_o(sync_pulse_o), .tx_enable_o(tx_enable_o));
`default_nettype wire

// [isp_sync2.v]
// Two-stage synchroniser for a bus of pin levels.
`default_nettype none
module isp_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta;
  // First stage feeds only the second stage.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the interleaved sample input port.
`default_nettype none
`include "isp_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, we, go, ack, irq, lclk, mark, sw;
  logic        dclk, dclk_oe, crst_n, frame_n, sdo, sdo_oe, alarm;
  logic        mf, syncp, txen, slp;
  logic [1:0]  np;
  logic [3:0]  adr;
  logic [13:0] data, wa, wb;
  logic [31:0] wdat, rdat, dat_o;
  logic [28:0] rows [4] = '{{1'b0, 14'h2001, 14'h1ffe},
    {1'b0, 14'h3fff, 14'h0000}, {1'b1, 14'h2001, 14'h1ffe},
    {1'b1, 14'h0aaa, 14'h1555}};
  int          bad_count, tests_run;
  isp_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
    .sample_data_i(data), .channel_marker_i(mark), .data_clk_i(lclk),
    .data_clk_o(dclk), .data_clk_oe_o(dclk_oe), .chip_reset_n_i(crst_n),
    .serial_frame_n_i(frame_n), .serial_data_i(1'b0),
    .serial_data_o(sdo), .serial_data_oe_o(sdo_oe),
    .alarm_or_read_out_o(alarm), .multi_func_i(mf),
    .sync_pulse_o(syncp), .tx_enable_o(txen), .sleep_o(slp));
  isp_host_model u_host (.go_i(go), .word_a_i(wa), .word_b_i(wb),
    .lclk_o(lclk), .data_o(data), .marker_o(mark));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog well past the few hundred cycles of the run.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #60us;
    bad_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Classic bus cycle: hold everything until ack is sampled high.
  task automatic wbx(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Word pairs from the table, then the pins and registers by hand.
  initial begin
    {rst_i, crst_n, frame_n, cyc, we, go, mf, sw} = 8'he0;
    {adr, wdat, wa, wb, bad_count, tests_run} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`ISP_ADR_CTRL, 32'h0);
    rd(`ISP_ADR_STATUS, 32'h1 << `ISP_EV_RESET);
    foreach (rows[i]) begin
      {sw, wa, wb} = rows[i];
      wr(`ISP_ADR_CTRL, 32'(sw) << `ISP_CTRL_SWAP);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (40) @(posedge clk_i);
      rd(`ISP_ADR_CHAN_A, 32'(sw ? wb : wa));
      rd(`ISP_ADR_CHAN_B, 32'(sw ? wa : wb));
    end
    // Phase words: whole words first, then upper and lower bytes.
    for (int p = 0; p < 2; p++) begin
      wr(`ISP_ADR_CTRL, p ? 32'h18 : 32'h08);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (40) @(posedge clk_i);
      rd(`ISP_ADR_PHASE, p ? {16'h0, wa[13:6], wb[13:6]}
                           : {16'h0, wb, 2'b00});
    end
    rd(4'h8, 32'h0);
    wr(`ISP_ADR_ALARM_SEL, 32'h2);
    chk(alarm, 32'h0);
    wr(`ISP_ADR_ALARM_SEL, 32'h8);
    chk(alarm, 32'h1);
    wr(`ISP_ADR_MASK, 32'h1);
    chk(irq, 32'h1);
    wr(`ISP_ADR_STATUS, 32'h3f);
    chk(irq, 32'h0);
    frame_n <= 1'b0;
    wr(`ISP_ADR_CTRL, 32'h81);
    wr(`ISP_ADR_SDO, 32'h1);
    chk(alarm, 32'h1);
    chk(sdo_oe, 32'h0);
    wr(`ISP_ADR_SDO, 32'h0);
    chk(alarm, 32'h0);
    wr(`ISP_ADR_CTRL, 32'h80);
    wr(`ISP_ADR_SDO, 32'h1);
    chk({sdo_oe, sdo}, 32'h3);
    frame_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(sdo_oe, 32'h0);
    wr(`ISP_ADR_CTRL, 32'h4);
    repeat (40) @(posedge clk_i);
    chk(dclk_oe, 32'h1);
    for (int m = 0; m < 3; m++) begin
      wr(`ISP_ADR_CTRL, 32'(m) << `ISP_CTRL_MF_LO);
      np = 2'h0;
      mf <= 1'b1;
      repeat (8) begin
        @(posedge clk_i);
        np += syncp;
      end
      chk({np, txen, slp}, 32'h4 >> m);
      mf <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    wr(`ISP_ADR_ALARM_SEL, 32'h2);
    crst_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk({irq, alarm}, 32'h1);
    crst_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(`ISP_ADR_ALARM_SEL, 32'h0);
    rd(`ISP_ADR_STATUS, 32'h1 << `ISP_EV_RESET);
    tally_and_finish();
  end
endmodule
`default_nettype wire
